// ===== scp_consts.svh
// Constants for the serial control port: register offsets, field positions, resets, timing
// Assumes inclusion by bare name from the package and the bench
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH
`define SCP_ADDR_W 13
`define SCP_MAP_DEPTH 32
`define SCP_REG_PORT_CFG 13'h0000
`define SCP_REG_READBACK 13'h0001
`define SCP_REG_UPDATE 13'h000F
`define SCP_CFG_LSB_A 1
`define SCP_CFG_LSB_B 6
`define SCP_CFG_ASC_A 2
`define SCP_CFG_ASC_B 5
`define SCP_CFG_3WIRE 3
`define SCP_RB_ACTIVE_BIT 5
`define SCP_UPD_BIT 0
`define SCP_CFG_RESET 8'h00
`define SCP_I2C_ADDR_HI 5'h15
`define SCP_ADDR_TOP 13'h1FFF
`define SCP_SCLK_DIV 4'h8
`define SCP_HOST_ADDR 8'h00
`define SCP_HOST_WDATA 8'h04
`define SCP_HOST_CTRL 8'h08
`define SCP_HOST_STATUS 8'h0C
`define SCP_HOST_RDATA 8'h10
`endif

// ===== scp_pkg.sv
// Types shared by both ends of the serial control port
// Assumes scp_consts.svh is on the include path
`include "scp_consts.svh"
package scp_pkg;
    typedef logic [`SCP_ADDR_W-1:0] scp_addr_t;
    typedef logic [7:0] scp_byte_t;
    typedef enum logic [1:0] {
        SCP_ST_IDLE = 2'b00,
        SCP_ST_INSTR = 2'b01,
        SCP_ST_DATA = 2'b11
    } scp_state_t;
endpackage

// ===== scp_if.sv
// Interface joining the serial master and the serial slave
// Assumes the bench resolves the shared data wire from the enables
interface scp_if;
    logic sclk;
    logic cs_n;
    logic sdio_m_o;
    logic sdio_m_oe_n;
    logic sdio_s_o;
    logic sdio_s_oe_n;
    logic sdio_i;
    logic serial_data_output_pin;
    logic serial_data_output_pin_oe_n;
    modport master (output sclk, output cs_n, output sdio_m_o, output sdio_m_oe_n,
                    input sdio_i, input serial_data_output_pin, input serial_data_output_pin_oe_n);
    modport slave (input sclk, input cs_n, input sdio_i, output sdio_s_o, output sdio_s_oe_n,
                   output serial_data_output_pin, output serial_data_output_pin_oe_n);
endinterface

// ===== scp_slave.sv
// Serial control port slave: strap sampling, instruction decode, streaming register access
// Assumes sclk, cs_n and data come from another domain and are sampled by i_clock
//
// Decided for this implementation: the Wishbone slave port.
module scp_slave (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Straps
    input wire logic i_port_select_strap_low,
    input wire logic i_port_select_strap_high,
    // Serial link
    scp_if.slave bus,
    // Status
    output logic o_spi_enabled,
    output logic [6:0] o_i2c_address,
    output logic [7:0] o_active_reg1
);
    import scp_pkg::*;
    typedef struct packed {
        logic [1:0] sclk_s2;
        logic [1:0] cs_s2;
        logic [1:0] sdi_s1;
        logic sclk_d;
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic spi_en;
        logic [1:0] strap;
        scp_state_t st;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic rd;
        scp_addr_t addr;
        logic lsb;
        logic [7:0] port_cfg;
        logic [7:0] obyte;
        logic dout;
        logic drive;
    } scp_slv_t;
    scp_slv_t cur_ff, nxt_ff;
    scp_byte_t buf_mem_ff [`SCP_MAP_DEPTH];
    scp_byte_t act_mem_ff [`SCP_MAP_DEPTH];
    logic wr_en, upd_en, rise, fall, cs_n, sdi, ldone;
    scp_addr_t waddr;
    scp_byte_t wbyte;

    // Map index from an address
    function automatic logic [4:0] scp_idx(input scp_addr_t a);
        scp_idx = a[4:0];
    endfunction

    // Read source for one address
    function automatic scp_byte_t scp_rd(input scp_addr_t a, input logic use_act, input logic [7:0] cfg);
        if (a == `SCP_REG_PORT_CFG) begin
            scp_rd = cfg;
        end else if (a >= scp_addr_t'(`SCP_MAP_DEPTH)) begin
            scp_rd = 8'h00;
        end else begin
            scp_rd = use_act ? act_mem_ff[scp_idx(a)] : buf_mem_ff[scp_idx(a)];
        end
    endfunction

    assign rise = cur_ff.sclk_s2[1] & ~cur_ff.sclk_d;
    assign fall = ~cur_ff.sclk_s2[1] & cur_ff.sclk_d;
    assign cs_n = cur_ff.cs_s2[1];
    assign sdi = cur_ff.sdi_s1[1];

    // Next-state logic
    always_comb begin
        logic [15:0] sh_n;
        logic use_act;
        scp_byte_t ob;
        sh_n = 16'h0000;
        use_act = 1'b0;
        ob = 8'h00;
        nxt_ff = cur_ff;
        wr_en = 1'b0;
        upd_en = 1'b0;
        waddr = cur_ff.addr;
        wbyte = 8'h00;
        ldone = 1'b0;
        nxt_ff.sclk_s2 = {cur_ff.sclk_s2[0], bus.sclk};
        nxt_ff.cs_s2 = {cur_ff.cs_s2[0], bus.cs_n};
        nxt_ff.sdi_s1 = {cur_ff.sdi_s1[0], bus.sdio_i};
        nxt_ff.sclk_d = cur_ff.sclk_s2[1];
        nxt_ff.strap_s1 = {i_port_select_strap_high, i_port_select_strap_low};
        nxt_ff.strap_s2 = cur_ff.strap_s1;
        // Straps caught once after reset release, once both sync stages hold pin levels
        if (!cur_ff.strap_done) begin
            nxt_ff.strap_cnt = cur_ff.strap_cnt + 2'h1;
            if (cur_ff.strap_cnt == 2'h2) begin
                nxt_ff.strap_done = 1'b1;
                nxt_ff.strap = cur_ff.strap_s2;
                nxt_ff.spi_en = ~cur_ff.strap_s2[1] & ~cur_ff.strap_s2[0];
            end
        end
        use_act = act_mem_ff[scp_idx(`SCP_REG_READBACK)][`SCP_RB_ACTIVE_BIT];
        sh_n = cur_ff.lsb ? {sdi, cur_ff.sh[15:1]} : {cur_ff.sh[14:0], sdi};
        if (cs_n || !cur_ff.spi_en) begin
            nxt_ff.st = SCP_ST_IDLE;
            nxt_ff.drive = 1'b0;
            nxt_ff.cnt = 5'h00;
            nxt_ff.lsb = cur_ff.port_cfg[`SCP_CFG_LSB_A] | cur_ff.port_cfg[`SCP_CFG_LSB_B];
        end else begin
            unique case (cur_ff.st)
                SCP_ST_IDLE: begin
                    nxt_ff.st = SCP_ST_INSTR;
                    nxt_ff.cnt = 5'h00;
                end
                SCP_ST_INSTR: begin
                    if (rise) begin
                        nxt_ff.sh = sh_n;
                        nxt_ff.cnt = cur_ff.cnt + 5'h01;
                        if (cur_ff.cnt == 5'h0F) begin
                            // Full 16-bit word; either shift order leaves instruction bit i at sh_n[i]
                            nxt_ff.rd = sh_n[15];
                            nxt_ff.addr = sh_n[12:0];
                            nxt_ff.st = SCP_ST_DATA;
                            nxt_ff.cnt = 5'h00;
                        end
                    end
                end
                SCP_ST_DATA: begin
                    if (cur_ff.rd) begin
                        // Load byte and drive bits on falling edges
                        if (fall) begin
                            ob = (cur_ff.cnt[2:0] == 3'h0) ? scp_rd(cur_ff.addr, use_act, cur_ff.port_cfg)
                                                           : cur_ff.obyte;
                            nxt_ff.dout = cur_ff.lsb ? ob[0] : ob[7];
                            nxt_ff.obyte = cur_ff.lsb ? {1'b0, ob[7:1]} : {ob[6:0], 1'b0};
                            nxt_ff.drive = 1'b1;
                        end
                        if (rise) begin
                            nxt_ff.cnt = cur_ff.cnt + 5'h01;
                            ldone = (cur_ff.cnt[2:0] == 3'h7);
                        end
                    end else if (rise) begin
                        nxt_ff.sh = sh_n;
                        nxt_ff.cnt = cur_ff.cnt + 5'h01;
                        if (cur_ff.cnt[2:0] == 3'h7) begin
                            wbyte = cur_ff.lsb ? sh_n[15:8] : sh_n[7:0];
                            ldone = 1'b1;
                            if (cur_ff.addr == `SCP_REG_PORT_CFG) begin
                                nxt_ff.port_cfg = wbyte;
                            end else if (cur_ff.addr == `SCP_REG_UPDATE) begin
                                upd_en = wbyte[`SCP_UPD_BIT];
                            end else begin
                                wr_en = 1'b1;
                            end
                        end
                    end
                    if (ldone) begin
                        // Step address each byte, no skipping
                        if (cur_ff.port_cfg[`SCP_CFG_ASC_A] | cur_ff.port_cfg[`SCP_CFG_ASC_B]) begin
                            nxt_ff.addr = cur_ff.addr + 13'h0001;
                        end else begin
                            nxt_ff.addr = cur_ff.addr - 13'h0001;
                        end
                    end
                end
                default: nxt_ff.st = SCP_ST_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cur_ff <= '0;
            cur_ff.cs_s2 <= 2'h3;
            cur_ff.port_cfg <= `SCP_CFG_RESET;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Buffer and active register arrays
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < `SCP_MAP_DEPTH; i++) begin
                buf_mem_ff[i] <= 8'h00;
                act_mem_ff[i] <= 8'h00;
            end
        end else begin
            if (wr_en && waddr < scp_addr_t'(`SCP_MAP_DEPTH)) begin
                buf_mem_ff[scp_idx(waddr)] <= wbyte;
            end
            if (upd_en) begin
                for (int i = 0; i < `SCP_MAP_DEPTH; i++) begin
                    act_mem_ff[i] <= buf_mem_ff[i];
                end
            end
        end
    end

    // Pin drive: released while chip select high
    always_comb begin
        logic en;
        logic three;
        en = cur_ff.drive & ~cs_n & cur_ff.spi_en;
        three = cur_ff.port_cfg[`SCP_CFG_3WIRE];
        bus.sdio_s_o = cur_ff.dout;
        bus.sdio_s_oe_n = ~(en & three);
        bus.serial_data_output_pin = cur_ff.dout;
        bus.serial_data_output_pin_oe_n = ~(en & ~three);
    end

    assign o_spi_enabled = cur_ff.spi_en;
    assign o_i2c_address = {`SCP_I2C_ADDR_HI, cur_ff.strap};
    assign o_active_reg1 = act_mem_ff[scp_idx(`SCP_REG_READBACK)];
endmodule

// ===== scp_master.sv
// Serial control port master with a classic Wishbone slave for its command registers
// Assumes the slave obeys the framing; returned data is sampled through two flip-flops
module scp_master (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Serial link
    scp_if.master bus
);
    import scp_pkg::*;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic lsb;
        logic three;
        logic busy;
        logic ack;
        logic [31:0] dat;
        logic [3:0] div;
        logic sclk;
        logic cs_n;
        logic [4:0] bit_n;
        logic [23:0] sh;
        logic oe_n;
        logic [1:0] sdi_s;
        logic [1:0] sdo_s;
    } scp_mst_t;
    scp_mst_t cur_ff, nxt_ff;
    logic wb_req;
    assign wb_req = i_wb_cyc & i_wb_stb & ~cur_ff.ack;

    // Next-state logic: bus slave and shifter
    always_comb begin
        logic rbit;
        rbit = cur_ff.three ? cur_ff.sdi_s[1] : cur_ff.sdo_s[1];
        nxt_ff = cur_ff;
        nxt_ff.sdi_s = {cur_ff.sdi_s[0], bus.sdio_i};
        nxt_ff.sdo_s = {cur_ff.sdo_s[0], bus.serial_data_output_pin};
        nxt_ff.ack = wb_req;
        nxt_ff.dat = 32'h00000000;
        if (wb_req) begin
            unique case (i_wb_adr)
                `SCP_HOST_ADDR: nxt_ff.dat = {16'h0000, cur_ff.addr};
                `SCP_HOST_WDATA: nxt_ff.dat = {24'h000000, cur_ff.wdata};
                `SCP_HOST_CTRL: nxt_ff.dat = {30'h0, cur_ff.three, cur_ff.lsb};
                `SCP_HOST_STATUS: nxt_ff.dat = {31'h0, cur_ff.busy};
                `SCP_HOST_RDATA: nxt_ff.dat = {24'h000000, cur_ff.rdata};
                default: nxt_ff.dat = 32'h00000000;
            endcase
            if (i_wb_we && !cur_ff.busy) begin
                if (i_wb_adr == `SCP_HOST_ADDR && i_wb_sel[0]) nxt_ff.addr[7:0] = i_wb_dat[7:0];
                if (i_wb_adr == `SCP_HOST_ADDR && i_wb_sel[1]) nxt_ff.addr[15:8] = i_wb_dat[15:8];
                if (i_wb_adr == `SCP_HOST_WDATA && i_wb_sel[0]) nxt_ff.wdata = i_wb_dat[7:0];
                if (i_wb_adr == `SCP_HOST_CTRL && i_wb_sel[0]) begin
                    nxt_ff.lsb = i_wb_dat[0];
                    nxt_ff.three = i_wb_dat[1];
                    // Bit 2 starts one single-byte transfer
                    if (i_wb_dat[2]) begin
                        nxt_ff.busy = 1'b1;
                        nxt_ff.cs_n = 1'b0;
                        nxt_ff.bit_n = 5'h00;
                        nxt_ff.div = 4'h0;
                        // LSB order shifts right, so the instruction must sit in the low bits
                        nxt_ff.sh = i_wb_dat[0] ? {cur_ff.wdata, cur_ff.addr} : {cur_ff.addr, cur_ff.wdata};
                        nxt_ff.oe_n = 1'b0;
                    end
                end
            end
        end
        // Divided clock, one byte framed by chip select
        if (cur_ff.busy) begin
            nxt_ff.div = cur_ff.div + 4'h1;
            if (cur_ff.div == `SCP_SCLK_DIV - 4'h1) begin
                nxt_ff.div = 4'h0;
                nxt_ff.sclk = ~cur_ff.sclk;
                if (cur_ff.sclk) begin
                    // Falling edge: advance output bit
                    nxt_ff.sh = cur_ff.lsb ? {1'b0, cur_ff.sh[23:1]} : {cur_ff.sh[22:0], 1'b0};
                    nxt_ff.bit_n = cur_ff.bit_n + 5'h01;
                    if (cur_ff.bit_n == 5'h0F && cur_ff.addr[15]) nxt_ff.oe_n = 1'b1;
                    if (cur_ff.bit_n == 5'h17) begin
                        nxt_ff.busy = 1'b0;
                        nxt_ff.cs_n = 1'b1;
                        nxt_ff.oe_n = 1'b1;
                    end
                end else if (cur_ff.bit_n >= 5'h10 && cur_ff.addr[15]) begin
                    // Rising edge: capture read bit driven on the previous fall
                    nxt_ff.rdata = cur_ff.lsb ? {rbit, cur_ff.rdata[7:1]} : {cur_ff.rdata[6:0], rbit};
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cur_ff <= '0;
            cur_ff.cs_n <= 1'b1;
            cur_ff.oe_n <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Outputs
    always_comb begin
        bus.sclk = cur_ff.sclk;
        bus.cs_n = cur_ff.cs_n;
        bus.sdio_m_o = cur_ff.lsb ? cur_ff.sh[0] : cur_ff.sh[23];
        bus.sdio_m_oe_n = cur_ff.oe_n | cur_ff.cs_n;
        o_wb_dat = cur_ff.dat;
        o_wb_ack = cur_ff.ack;
    end
endmodule

// ===== scp_chk_props.sv
// Concurrent checks on the serial link between the two ends of the control port
// Assumes the bench feeds the interface signals and the system clock and reset
module scp_chk (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_m_oe_n,
    input wire logic sdio_s_oe_n,
    input wire logic serial_data_output_pin,
    input wire logic serial_data_output_pin_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sclk_q_ff;
    logic [5:0] rise_cnt_ff;

    // Counts serial clock rises inside one frame
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            sclk_q_ff <= 1'b0;
            rise_cnt_ff <= 6'h00;
        end else begin
            sclk_q_ff <= sclk;
            if (cs_n) rise_cnt_ff <= 6'h00;
            else if (sclk && !sclk_q_ff) rise_cnt_ff <= rise_cnt_ff + 6'h01;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    // High phase of the serial clock, then its fall
    sequence s_high_phase;
        sclk [*8];
    endsequence
    sequence s_fall;
        !sclk;
    endsequence

    property p_release;
        cs_n [*4] |-> sdio_s_oe_n && serial_data_output_pin_oe_n;
    endproperty
    property p_one_out;
        !(!sdio_s_oe_n && !serial_data_output_pin_oe_n);
    endproperty
    property p_no_fight;
        !(!sdio_m_oe_n && !sdio_s_oe_n);
    endproperty
    property p_out_stable;
        sclk && $past(sclk) && !serial_data_output_pin_oe_n && !$past(serial_data_output_pin_oe_n)
            |-> $stable(serial_data_output_pin);
    endproperty
    property p_frame_start;
        $fell(cs_n) |-> !sclk;
    endproperty
    property p_idle_clk;
        cs_n && $past(cs_n) |-> !sclk;
    endproperty
    property p_count;
        $rose(cs_n) |-> rise_cnt_ff == 6'd24;
    endproperty
    property p_half_period;
        $rose(sclk) |-> s_high_phase ##1 s_fall;
    endproperty
    property p_instr_drive;
        !cs_n && sclk && rise_cnt_ff < 6'd15 |-> !sdio_m_oe_n;
    endproperty

    a_release: assert property (p_release) else $error("data pins driven while deselected");
    a_one_out: assert property (p_one_out) else $error("both slave outputs driven");
    a_no_fight: assert property (p_no_fight) else $error("both ends drive the data wire");
    a_out_stable: assert property (p_out_stable) else $error("read data moved while clock high");
    a_frame_start: assert property (p_frame_start) else $error("frame opened with clock high");
    a_idle_clk: assert property (p_idle_clk) else $error("clock moves outside frame");
    a_count: assert property (p_count) else $error("frame edge count wrong");
    a_half_period: assert property (p_half_period) else $error("clock high phase wrong");
    a_instr_drive: assert property (p_instr_drive) else $error("instruction not driven by master");
endmodule

// ===== tb.sv
// Bench: Wishbone-driven master facing the slave, register and wire checks
// Assumes both design ends, the interface and the package are compiled first
`include "scp_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import scp_pkg::*;
    logic i_clock = 1'b0, i_rstn = 1'b0, strap_lo = 1'b0, strap_hi = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, spi_en, idle_q = 1'b0, lsb = 1'b0, three = 1'b0;
    logic [6:0] i2c_adr;
    logic [7:0] act1;
    logic [23:0] sh = 24'h0;
    int miscompares = 0, n_compared = 0, n_rise = 0, cyc_cnt = 0;
    scp_if bus();
    scp_master i_scp_master(.i_clock(i_clock), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .bus(bus));
    scp_slave i_scp_slave(.i_clock(i_clock), .i_rstn(i_rstn), .i_port_select_strap_low(strap_lo),
        .i_port_select_strap_high(strap_hi), .bus(bus), .o_spi_enabled(spi_en), .o_i2c_address(i2c_adr),
        .o_active_reg1(act1));
    scp_chk i_scp_chk(.i_clock(i_clock), .i_rstn(i_rstn), .sclk(bus.sclk), .cs_n(bus.cs_n),
        .sdio_m_oe_n(bus.sdio_m_oe_n), .sdio_s_oe_n(bus.sdio_s_oe_n),
        .serial_data_output_pin(bus.serial_data_output_pin),
        .serial_data_output_pin_oe_n(bus.serial_data_output_pin_oe_n));
    // Shared wire: an undriven line shows a level that changes every cycle
    assign bus.sdio_i = !bus.sdio_m_oe_n ? bus.sdio_m_o : (!bus.sdio_s_oe_n ? bus.sdio_s_o : idle_q);
    // Clock generation
    initial begin
        forever #25 i_clock = ~i_clock;
    end
    // Idle pattern and hang limit
    always @(posedge i_clock) begin
        idle_q <= !idle_q;
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    // Wire monitor: clears its rise count on frame start, shifts in every bit seen on a serial clock rise
    always @(posedge bus.sclk or negedge bus.cs_n) begin
        if (!bus.sclk) begin
            n_rise <= 0;
        end else if (!bus.cs_n) begin
            sh <= {sh[22:0], (!bus.serial_data_output_pin_oe_n ? bus.serial_data_output_pin : bus.sdio_i)};
            n_rise <= n_rise + 1;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge i_clock); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // One serial transfer; e is the written byte or the expected read byte
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] e);
        logic [31:0] r;
        logic [15:0] ins;
        logic [15:0] ins_w;
        logic [7:0] e_w;
        ins = {rd, a};
        if (lsb) begin
            ins_w = {<<{ins}};
            e_w = {<<{e}};
        end else begin
            ins_w = ins;
            e_w = e;
        end
        wb(1'b1, `SCP_HOST_ADDR, {16'h0, ins}, r);
        wb(1'b1, `SCP_HOST_WDATA, {24'h0, e}, r);
        wb(1'b1, `SCP_HOST_CTRL, {29'h0, 1'b1, three, lsb}, r);
        do wb(1'b0, `SCP_HOST_STATUS, 32'h0, r); while (r[0] !== 1'b0);
        wb(1'b0, `SCP_HOST_RDATA, 32'h0, r);
        if (rd) chk("read byte", {24'h0, e}, {24'h0, r[7:0]});
        chk("edge count", 24, n_rise);
        chk("instruction on wire", {16'h0, ins_w}, {16'h0, sh[23:8]});
        chk("byte on wire", {24'h0, e_w}, {24'h0, sh[7:0]});
        chk("pins released", 2'b11, {bus.sdio_s_oe_n, bus.serial_data_output_pin_oe_n});
    endtask
    task automatic do_reset(input logic lo, input logic hi);
        @(posedge i_clock);
        i_rstn <= 1'b0;
        strap_lo <= lo;
        strap_hi <= hi;
        repeat (12) @(posedge i_clock);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clock);
    endtask
    task automatic complete_run();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        logic [31:0] r;
        do_reset(1'b0, 1'b0);
        chk("spi enabled", 1, spi_en);
        chk("i2c address", 7'h54, i2c_adr);
        wb(1'b0, 8'h20, 32'h0, r);
        chk("unmapped host reg", 0, r);
        xfer(1'b1, 15'h0000, `SCP_CFG_RESET);
        xfer(1'b0, 15'h0003, 8'h5A);
        xfer(1'b1, 15'h0003, 8'h5A);
        xfer(1'b0, 15'h0001, 8'h20);
        chk("active reg1 before update", 8'h00, act1);
        xfer(1'b0, 15'h000F, 8'h01);
        chk("active reg1 after update", 8'h20, act1);
        xfer(1'b0, 15'h0002, 8'hA5);
        xfer(1'b1, 15'h0002, 8'h00);
        xfer(1'b0, 15'h000F, 8'h01);
        xfer(1'b1, 15'h6002, 8'hA5);
        xfer(1'b1, 15'h0028, 8'h00);
        xfer(1'b0, 15'h0000, 8'h08);
        three = 1'b1;
        xfer(1'b1, 15'h0002, 8'hA5);
        xfer(1'b0, 15'h0000, 8'h4A);
        lsb = 1'b1;
        xfer(1'b1, 15'h0002, 8'hA5);
        xfer(1'b0, 15'h0000, 8'h00);
        lsb = 1'b0;
        three = 1'b0;
        xfer(1'b1, 15'h0000, 8'h00);
        chk("spi kept", 1, spi_en);
        do_reset(1'b1, 1'b0);
        chk("spi off", 0, spi_en);
        chk("i2c address", 7'h55, i2c_adr);
        complete_run();
    end
endmodule
